// ---- logic/bsa_pkg.sv ----
/*
 * Package for the backup supply and aging control block: register offsets,
 * field positions, reset values and the supply policy encodings.
 * Assumes a simple byte-wide register port with address, write strobe and
 * read data that settles one clock after the address.
 */
// Behaviour
// - Trim register at 30h keeps its code in bits 3..0; upper bits read zero.
// - Each trim step is 2 ppm: 0000 gives +16, 1111 gives -14.
// - Trim adds as a signed term to the temperature correction.
// - Policy field picks standard or direct, each with or without low-battery detect, or disabled.
// - Standard mode fails over only when main is below battery and threshold.
// - Direct mode fails over whenever main is below battery; no threshold check.
// - Fail-over sets the backup-switched flag.
// - Fail-over interrupt only when the backup-switch interrupt enable is set.
// - With stamp enable set, fail-over captures time into timestamp set 4.
// - Backup-switched flag holds until the host clears it; clearing drops the interrupt.
// - On battery, host interface inputs are ignored; nothing can be written.
// - On battery, interface outputs and square-wave output go high impedance.
// - Fail-over disabled: main supply only, backup-switched flag held at zero.
// - Low-battery flag follows the comparator when detection is on; writes cannot clear.
// - Low-battery interrupt only when its enable bit is set.
`default_nettype none

package bsa_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] BSA_ADDR_AGE_TRIM = 8'h30;
    localparam logic [7:0] BSA_ADDR_SUPPLY_CTL = 8'h31;
    localparam logic [7:0] BSA_ADDR_SUPPLY_STAT = 8'h32;

    // ==========================================================
    // field positions
    localparam int BSA_POS_LBIE = 0;
    localparam int BSA_POS_BIE = 1;
    localparam int BSA_POS_BACKUP_SWITCH_STAMP_EN = 2;
    localparam int BSA_POS_POLICY = 5;
    localparam int BSA_POS_BF = 3;
    localparam int BSA_POS_BLF = 2;
    localparam int BSA_POS_ONBAT = 0;

    // ==========================================================
    // reset values
    localparam logic [3:0] BSA_RST_AGE_TRIM = 4'h8;
    localparam logic [2:0] BSA_RST_POLICY = 3'h7;

    // ==========================================================
    // supply policy decoded mode
    typedef enum logic [1:0] {
        BSA_MODE_OFF = 2'b00,
        BSA_MODE_STD = 2'b01,
        BSA_MODE_DIRECT = 2'b10
    } bsa_mode_type;

    // ==========================================================
    // supply state machine
    typedef enum logic [0:0] {
        BSA_ST_MAIN = 1'b0,
        BSA_ST_BATT = 1'b1
    } bsa_state_type;

endpackage

`default_nettype wire

// ---- logic/bsa_trim.sv ----
/*
 * Aging trim adder: turns the 4-bit aging code into a signed ppm step and
 * adds it to the temperature-derived correction, registered.
 * Assumes the temperature correction is a signed count in 2 ppm units.
 */
`default_nettype none

module bsa_trim
    import bsa_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // correction inputs
    input wire logic [3:0] i_code,
    input wire logic signed [7:0] i_temp_corr,
    // summed correction, 2 ppm units
    output logic signed [7:0] o_total_corr
);

    // ==========================================================
    // code to signed step: 8 minus code, so 0 -> +8 (16 ppm), 15 -> -7
    function automatic logic signed [7:0] code_step(input logic [3:0] code);
        code_step = 8'sh08 - $signed({4'h0, code});
    endfunction

    // register the sum so the compensation path sees a clean value
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_total_corr <= 8'sh00;
        end else begin
            o_total_corr <= i_temp_corr + code_step(i_code);
        end
    end

endmodule

`default_nettype wire

// ---- logic/bsa_ctrl.sv ----
/*
 * Backup supply and aging control: register port, supply policy,
 * fail-over state machine, flags and interrupts, interface gating.
 * Assumes supply comparators arrive asynchronously as pins and the register
 * port is driven from the host interface logic on the same clock.
 */
`default_nettype none

module bsa_ctrl
    import bsa_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // host interface gating
    input wire logic i_host_oe,
    output logic o_host_oe,
    output logic o_host_in_en,
    // square-wave output enable
    input wire logic i_square_wave_oe,
    output logic o_square_wave_oe,
    // comparators, asynchronous
    input wire logic i_main_below_batt,
    input wire logic i_main_below_thresh,
    input wire logic i_batt_low,
    // temperature compensation
    input wire logic signed [7:0] i_temp_corr,
    output logic signed [7:0] o_total_corr,
    // events
    output logic o_stamp4_capture,
    output logic o_irq_backup,
    output logic o_irq_low_batt,
    output logic o_on_battery
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [3:0] age_trim_code;
        logic [2:0] supply_policy_select;
        logic backup_switch_irq_en;
        logic backup_switch_stamp_en;
        logic low_battery_irq_en;
        logic backup_switched_flag;
        logic low_battery_flag;
        bsa_state_type supply_state;
        logic [2:0] sync_mbb;
        logic [2:0] sync_mbt;
        logic [2:0] sync_bl;
        logic mbb;
        logic mbt;
        logic bl;
        logic [7:0] rdata;
        logic host_oe;
        logic host_in_en;
        logic square_wave_oe;
        logic stamp4;
        logic irq_backup;
        logic irq_low;
    } bsa_regs_type;

    bsa_regs_type r;
    bsa_regs_type next_r;
    bsa_mode_type mode;
    logic detect_en;
    logic fail;
    logic wr_ok;

    // ==========================================================
    // policy decode
    function automatic bsa_mode_type decode_mode(input logic [2:0] p);
        if (p <= 3'h2) begin
            decode_mode = BSA_MODE_STD;
        end else if (p <= 3'h5) begin
            decode_mode = BSA_MODE_DIRECT;
        end else begin
            decode_mode = BSA_MODE_OFF;
        end
    endfunction

    function automatic logic decode_detect(input logic [2:0] p);
        decode_detect = (p == 3'h0) || (p == 3'h3);
    endfunction

    // policy is read live from the register, so a write acts next cycle
    assign mode = decode_mode(r.supply_policy_select);
    assign detect_en = decode_detect(r.supply_policy_select);

    // failure condition per mode
    always_comb begin
        case (mode)
            BSA_MODE_STD: fail = r.mbb && r.mbt;
            BSA_MODE_DIRECT: fail = r.mbb;
            default: fail = 1'b0;
        endcase
    end

    // writes refused while on battery
    assign wr_ok = i_wr && (r.supply_state == BSA_ST_MAIN);

    // ==========================================================
    // next state
    always_comb begin
        next_r = r;
        next_r.stamp4 = 1'b0;
        // three-stage synchronisers; a change counts when stages two and three agree
        next_r.sync_mbb = {r.sync_mbb[1:0], i_main_below_batt};
        next_r.sync_mbt = {r.sync_mbt[1:0], i_main_below_thresh};
        next_r.sync_bl = {r.sync_bl[1:0], i_batt_low};
        if (r.sync_mbb[2] == r.sync_mbb[1]) begin
            next_r.mbb = r.sync_mbb[2];
        end
        if (r.sync_mbt[2] == r.sync_mbt[1]) begin
            next_r.mbt = r.sync_mbt[2];
        end
        if (r.sync_bl[2] == r.sync_bl[1]) begin
            next_r.bl = r.sync_bl[2];
        end
        // register writes; the flag clear comes first so a same-cycle switch wins
        if (wr_ok) begin
            if (i_addr == BSA_ADDR_AGE_TRIM) begin
                next_r.age_trim_code = i_wdata[3:0];
            end else if (i_addr == BSA_ADDR_SUPPLY_CTL) begin
                next_r.supply_policy_select = i_wdata[BSA_POS_POLICY +: 3];
                next_r.backup_switch_stamp_en = i_wdata[BSA_POS_BACKUP_SWITCH_STAMP_EN];
                next_r.backup_switch_irq_en = i_wdata[BSA_POS_BIE];
                next_r.low_battery_irq_en = i_wdata[BSA_POS_LBIE];
            end else if (i_addr == BSA_ADDR_SUPPLY_STAT) begin
                if (!i_wdata[BSA_POS_BF]) begin
                    next_r.backup_switched_flag = 1'b0;
                end
            end
        end
        // supply state machine
        case (r.supply_state)
            BSA_ST_MAIN: begin
                if (fail) begin
                    next_r.supply_state = BSA_ST_BATT;
                    next_r.backup_switched_flag = 1'b1;
                    next_r.stamp4 = r.backup_switch_stamp_en;
                end
            end
            BSA_ST_BATT: begin
                if (!fail) begin
                    next_r.supply_state = BSA_ST_MAIN;
                end
            end
            default: next_r.supply_state = BSA_ST_MAIN;
        endcase
        // disabled switch-over pins the flag low
        if (mode == BSA_MODE_OFF) begin
            next_r.backup_switched_flag = 1'b0;
        end
        // low battery follows the comparator; no write path clears it
        next_r.low_battery_flag = detect_en && r.bl;
        // interrupts
        next_r.irq_backup = next_r.backup_switched_flag && next_r.backup_switch_irq_en;
        next_r.irq_low = next_r.low_battery_flag && next_r.low_battery_irq_en;
        // output gating on battery
        next_r.host_oe = i_host_oe && (next_r.supply_state == BSA_ST_MAIN);
        next_r.square_wave_oe = i_square_wave_oe && (next_r.supply_state == BSA_ST_MAIN);
        next_r.host_in_en = (next_r.supply_state == BSA_ST_MAIN);
        // read data, unused bits zero
        if (i_addr == BSA_ADDR_AGE_TRIM) begin
            next_r.rdata = {4'h0, r.age_trim_code};
        end else if (i_addr == BSA_ADDR_SUPPLY_CTL) begin
            next_r.rdata = {r.supply_policy_select, 2'b00, r.backup_switch_stamp_en,
                            r.backup_switch_irq_en, r.low_battery_irq_en};
        end else if (i_addr == BSA_ADDR_SUPPLY_STAT) begin
            next_r.rdata = {4'h0, r.backup_switched_flag, r.low_battery_flag, 1'b0,
                            r.supply_state == BSA_ST_BATT};
        end else begin
            next_r.rdata = 8'h00;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r <= '0;
            r.age_trim_code <= BSA_RST_AGE_TRIM;
            r.supply_policy_select <= BSA_RST_POLICY;
            r.supply_state <= BSA_ST_MAIN;
            r.host_in_en <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // aging trim into the compensation path
    bsa_trim u_trim (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_code(r.age_trim_code),
        .i_temp_corr(i_temp_corr),
        .o_total_corr(o_total_corr)
    );

    // outputs straight from flops
    assign o_rdata = r.rdata;
    assign o_host_oe = r.host_oe;
    assign o_host_in_en = r.host_in_en;
    assign o_square_wave_oe = r.square_wave_oe;
    assign o_stamp4_capture = r.stamp4;
    assign o_irq_backup = r.irq_backup;
    assign o_irq_low_batt = r.irq_low;
    assign o_on_battery = (r.supply_state == BSA_ST_BATT);

endmodule

`default_nettype wire

// ---- test/bsa_ctrl_properties.sv ----
/* checker: gating, stamp and trim read properties of bsa_ctrl.
   assumes it is bound to bsa_ctrl and sees only its ports. */
`default_nettype none
module bsa_ctrl_properties (
    // watched ports
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] o_rdata,
    input wire logic i_host_oe,
    input wire logic o_host_oe,
    input wire logic o_host_in_en,
    input wire logic o_square_wave_oe,
    input wire logic i_main_below_batt,
    input wire logic o_stamp4_capture,
    input wire logic o_irq_backup,
    input wire logic o_on_battery
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // properties, all in the one clock domain
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_trim_upper_zero: assert property ($past(i_addr) == 8'h30 |-> o_rdata[7:4] == 4'h0)
        else $error("trim upper bits not zero");
    a_main_stays_main: assert property (!i_main_below_batt [*8] |=> !o_on_battery)
        else $error("on battery with main above battery");
    a_stamp_on_edge: assert property (o_stamp4_capture |-> $rose(o_on_battery))
        else $error("stamp without switch-over");
    a_stamp_single: assert property (o_stamp4_capture |=> !o_stamp4_capture)
        else $error("stamp repeated");
    a_sqw_gated: assert property (o_on_battery |-> !o_square_wave_oe)
        else $error("square wave driven on battery");
    a_host_oe_gate: assert property (!$past(i_rst) |->
        o_host_oe == ($past(i_host_oe) && !o_on_battery)) else $error("host oe gating wrong");
    a_host_in_gate: assert property (o_host_in_en == !o_on_battery)
        else $error("host inputs accepted on battery");
    a_irq_holds: assert property (o_irq_backup && !i_wr && !$past(i_wr) |=> o_irq_backup)
        else $error("backup irq dropped without host write");
endmodule
bind bsa_ctrl bsa_ctrl_properties u_bsa_ctrl_properties (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr(i_wr), .o_rdata(o_rdata), .i_host_oe(i_host_oe),
    .o_host_oe(o_host_oe), .o_host_in_en(o_host_in_en), .o_square_wave_oe(o_square_wave_oe),
    .i_main_below_batt(i_main_below_batt), .o_stamp4_capture(o_stamp4_capture),
    .o_irq_backup(o_irq_backup), .o_on_battery(o_on_battery));
`default_nettype wire

// ---- test/bsa_host_model.sv ----
/* host processor model: byte register writes and reads.
   assumes the device takes a write on one edge and answers reads one cycle later. */
`default_nettype none
module bsa_host_model (
    // clock
    input wire logic i_mclk,
    // register port toward the device
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    // one write; also how the host clears the backup flag
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_mclk);
        #1;
        o_wr = 1'b0;
        o_wdata = ~d; // released data must not look valid
    endtask
    // read waits for the registered answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        #1;
        o_addr = a;
        repeat (2) @(posedge i_mclk);
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ---- test/bsa_ctrl_tb_top.sv ----
/* testbench for bsa_ctrl: trim, supply policies, flags, gating.
   assumes the host model drives the register port. */
`default_nettype none
module bsa_ctrl_tb_top;
    import bsa_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_host_oe, i_square_wave_oe, i_main_below_batt, i_main_below_thresh, i_batt_low;
    logic [7:0] i_addr, i_wdata, o_rdata, rv, en;
    logic i_wr, o_host_oe, o_host_in_en, o_square_wave_oe, o_stamp4_capture;
    logic o_irq_backup, o_irq_low_batt, o_on_battery, fail, det;
    logic signed [7:0] i_temp_corr, o_total_corr;
    logic [3:0] code;
    int error_cnt = 0;
    int checks = 0;
    int stamp_n = 0;
    always #10 i_mclk = ~i_mclk;
    // count stamp pulses mid-cycle, clear of the edge that launches them
    always @(negedge i_mclk) if (o_stamp4_capture === 1'b1) stamp_n++;
    bsa_ctrl u_bsa_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .i_host_oe(i_host_oe), .o_host_oe(o_host_oe),
        .o_host_in_en(o_host_in_en), .i_square_wave_oe(i_square_wave_oe),
        .o_square_wave_oe(o_square_wave_oe), .i_main_below_batt(i_main_below_batt),
        .i_main_below_thresh(i_main_below_thresh), .i_batt_low(i_batt_low),
        .i_temp_corr(i_temp_corr), .o_total_corr(o_total_corr),
        .o_stamp4_capture(o_stamp4_capture), .o_irq_backup(o_irq_backup),
        .o_irq_low_batt(o_irq_low_batt), .o_on_battery(o_on_battery));
    bsa_host_model u_bsa_host_model (.i_mclk(i_mclk), .o_addr(i_addr), .o_wr(i_wr),
        .o_wdata(i_wdata), .i_rdata(o_rdata));
    // ==========================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // code 8 is the zero point, each step is one 2 ppm unit
    function automatic logic [7:0] exp_corr(input logic [3:0] c, input logic [7:0] t);
        return t + 8'h08 - {4'h0, c};
    endfunction
    // ==========================================================
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge i_mclk);
        error_cnt++;
        final_report();
    end
    // ==========================================================
    // main sequence
    initial begin
        // comparators idle, so the first policy under test starts from main supply
        {i_host_oe, i_square_wave_oe, i_main_below_batt, i_main_below_thresh} = 4'hC;
        i_batt_low = 1'b0;
        i_temp_corr = 8'sh00;
        void'($urandom(8));
        cyc(3);
        i_rst = 1'b0;
        u_bsa_host_model.rd(8'h30, rv);
        chk(rv, 8'h08);
        u_bsa_host_model.rd(8'h31, rv);
        chk(rv, 8'hE0);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            code = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
            i_temp_corr = 8'($urandom % 64) - 8'sh20;
            u_bsa_host_model.wr(8'h30, {4'($urandom), code});
            u_bsa_host_model.rd(8'h30, rv);
            chk(rv, {4'h0, code});
            chk(o_total_corr, exp_corr(code, i_temp_corr));
        end
        $display("test trim done");
        // every policy code, random enables, no reset between them
        for (int p = 0; p < 8; p++) begin
            en = 8'($urandom % 8);
            fail = p <= 5;
            det = (p == 0) || (p == 3);
            i_host_oe = 1'($urandom);
            i_square_wave_oe = 1'($urandom);
            u_bsa_host_model.wr(8'h31, {3'(p), 2'b00, en[2:0]});
            stamp_n = 0;
            i_batt_low = 1'b1;
            i_main_below_batt = 1'b1;
            cyc(8);
            chk(o_on_battery, p >= 3 && p <= 5);
            i_main_below_thresh = 1'b1;
            cyc(8);
            chk(o_on_battery, fail);
            if (fail) u_bsa_host_model.wr(8'h30, 8'h03);
            chk(o_host_in_en, !fail);
            chk(o_host_oe, i_host_oe && !fail);
            chk(o_square_wave_oe, i_square_wave_oe && !fail);
            chk(o_irq_backup, fail && en[1]);
            chk(8'(stamp_n), fail && en[2]);
            chk(o_irq_low_batt, det && en[0]);
            {i_main_below_batt, i_main_below_thresh} = 2'b00;
            cyc(8);
            u_bsa_host_model.rd(8'h32, rv);
            chk(rv, {4'h0, fail, det, 2'b00});
            u_bsa_host_model.wr(8'h32, 8'h00);
            u_bsa_host_model.rd(8'h32, rv);
            chk(rv, {4'h0, 1'b0, det, 2'b00});
            chk(o_irq_backup, 1'b0);
            u_bsa_host_model.rd(8'h30, rv);
            chk(rv, {4'h0, code});
            i_batt_low = 1'b0;
            cyc(8);
            chk(o_irq_low_batt, 1'b0);
        end
        $display("test policy done");
        // second reset in mid-run: trim, policy and enables return to defaults
        i_rst = 1'b1;
        cyc(3);
        i_rst = 1'b0;
        u_bsa_host_model.rd(8'h30, rv);
        chk(rv, 8'h08);
        u_bsa_host_model.rd(8'h31, rv);
        chk(rv, 8'hE0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
